// ===== hdl/fpsc_top.sv
// Purpose: finger presence status and soft tap gesture detection
// Assumes: finger and motion inputs come from logic on clk
// Notes: deltas arrive already at 500 cpi; time registers count ticks
`timescale 1ns/10ps
`include "fpsc_cfg.svh"
module fpsc_top import fpsc_pkg::*; #(
	parameter int TICK_CYCLES = `FPSC_TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// register port from the serial engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// finger detect logic
	input  wire logic       finger_present_flag,
	input  wire logic [3:0] finger_hyst_bound,
	input  wire logic [2:0] quality_hyst_bound,
	// motion samples, signed, 500 cpi
	input  wire logic       motion_valid,
	input  wire logic [7:0] delta_x,
	input  wire logic [7:0] delta_y,
	// derived thresholds and gesture flags
	output logic      [6:0] finger_hyst_threshold,
	output logic      [4:0] quality_hyst_threshold,
	output logic      [2:0] gesture_flags
);
	function automatic logic [7:0] mag8(input logic [7:0] v);
		mag8 = v[7] ? 8'(~v + 8'h01) : v;
	endfunction

	function automatic logic [7:0] sat_inc8(input logic [7:0] v);
		sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
	endfunction

	fpsc_state_t state_reg;
	fpsc_state_t state_next;
	logic [7:0]  status_reg;
	logic [7:0]  timer_reg;
	logic [7:0]  timer_next;
	logic [9:0]  sum_reg;
	logic [9:0]  sum_next;
	logic [2:0]  flag_set;
	logic [7:0]  ctrl_reg;
	logic [7:0]  hold_reg;
	logic [7:0]  window_reg;
	logic [7:0]  limit_reg;
	logic [2:0]  flags_reg;
	logic        tick;

	fpsc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk    (clk),
		.resetn (resetn),
		.tick   (tick)
	);

	fpsc_regs u_regs (
		.clk          (clk),
		.resetn       (resetn),
		.reg_addr     (reg_addr),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_wdata    (reg_wdata),
		.reg_rdata    (reg_rdata),
		.status_value (status_reg),
		.flag_set     (flag_set),
		.ctrl_reg     (ctrl_reg),
		.hold_reg     (hold_reg),
		.window_reg   (window_reg),
		.limit_reg    (limit_reg),
		.flags_reg    (flags_reg)
	);

	wire       single_en  = ctrl_reg[`FPSC_CTRL_SINGLE];
	wire       double_en  = ctrl_reg[`FPSC_CTRL_DOUBLE];
	wire       hold_en    = ctrl_reg[`FPSC_CTRL_HOLD];
	wire [2:0] hold_timer_reset_level = ctrl_reg[`FPSC_CTRL_LVL_HI:`FPSC_CTRL_LVL_LO];

	// deltas are taken as 500 cpi counts whatever resolution is reported
	wire [8:0] sample_mag = {1'b0, mag8(delta_x)} + {1'b0, mag8(delta_y)};
	wire [9:0] sum_add    = sum_reg + {1'b0, sample_mag};
	// saturate so a long drag never wraps back under the limit
	wire [9:0] sum_acc    = (sum_add < sum_reg) ? 10'h3ff : sum_add;
	wire       motion_ok  = sum_reg < {2'b00, limit_reg};
	// jitter above the reset level restarts the hold wait
	wire       hold_jolt  = motion_valid && (sample_mag > {6'b00_0000, hold_timer_reset_level});
	wire       hold_due   = timer_reg >= hold_reg;
	wire       window_out = timer_reg >= window_reg;
	wire [7:0] timer_inc  = tick ? sat_inc8(timer_reg) : timer_reg;

	always_comb begin
		state_next = state_reg;
		timer_next = timer_inc;
		sum_next   = sum_reg;
		flag_set   = 3'b000;
		case (state_reg)
			FPSC_IDLE: begin
				timer_next = 8'h00;
				sum_next   = 10'h000;
				if (finger_present_flag)
					state_next = FPSC_PRESS1;
			end
			FPSC_PRESS1: begin
				if (motion_valid)
					sum_next = sum_acc;
				if (hold_jolt)
					timer_next = 8'h00;
				if (!finger_present_flag) begin
					timer_next = 8'h00;
					state_next = FPSC_IDLE;
					if (motion_ok && double_en)
						state_next = FPSC_WAIT2;
					else if (motion_ok && single_en)
						flag_set[`FPSC_FLAG_SINGLE] = 1'b1;
				end else if (hold_en && hold_due && motion_ok) begin
					flag_set[`FPSC_FLAG_HOLD] = 1'b1;
					state_next = FPSC_HELD;
				end
			end
			FPSC_WAIT2: begin
				if (finger_present_flag && !window_out) begin
					state_next = FPSC_PRESS2;
					sum_next   = 10'h000;
				end else if (window_out) begin
					state_next = FPSC_IDLE;
					flag_set[`FPSC_FLAG_SINGLE] = single_en;
				end
			end
			FPSC_PRESS2: begin
				if (motion_valid)
					sum_next = sum_acc;
				if (!finger_present_flag) begin
					state_next = FPSC_IDLE;
					flag_set[`FPSC_FLAG_DOUBLE] = motion_ok;
				end
			end
			FPSC_HELD: begin
				if (!finger_present_flag)
					state_next = FPSC_IDLE;
			end
			default: begin
				state_next = FPSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= FPSC_IDLE;
			timer_reg <= 8'h00;
			sum_reg   <= 10'h000;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			sum_reg   <= sum_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_reg             <= `FPSC_RST_STATUS;
			finger_hyst_threshold  <= 7'h00;
			quality_hyst_threshold <= 5'h00;
			gesture_flags          <= 3'b000;
		end else begin
			status_reg             <= {finger_hyst_bound, quality_hyst_bound, finger_present_flag};
			finger_hyst_threshold  <= {finger_hyst_bound, 3'b000};
			quality_hyst_threshold <= {quality_hyst_bound, 2'b00};
			gesture_flags          <= flags_reg;
		end
	end

	sequence s_first_valid_release;
		state_reg == FPSC_PRESS1 && !finger_present_flag && motion_ok;
	endsequence

	sequence s_second_touch_late;
		state_reg == FPSC_WAIT2 && window_out;
	endsequence

	a_finger_thresh: assert property (@(posedge clk) disable iff (!resetn)
		##1 finger_hyst_threshold == 7'd8 * 7'($past(finger_hyst_bound)))
		else $error("finger hysteresis threshold not eight times bound");
	a_quality_thresh: assert property (@(posedge clk) disable iff (!resetn)
		##1 quality_hyst_threshold == 5'd4 * 5'($past(quality_hyst_bound)))
		else $error("quality hysteresis threshold not four times bound");
	a_single_gate: assert property (@(posedge clk) disable iff (!resetn)
		flag_set[`FPSC_FLAG_SINGLE] |-> single_en && motion_ok)
		else $error("single tap flagged while disabled or moving");
	a_double_gate: assert property (@(posedge clk) disable iff (!resetn)
		s_first_valid_release ##1 state_reg == FPSC_WAIT2 |-> $past(double_en))
		else $error("double tap wait entered while disabled");
	a_hold_gate: assert property (@(posedge clk) disable iff (!resetn)
		flag_set[`FPSC_FLAG_HOLD] |-> hold_en && state_reg == FPSC_PRESS1)
		else $error("hold flagged while disabled");
	a_hold_delay: assert property (@(posedge clk) disable iff (!resetn)
		flag_set[`FPSC_FLAG_HOLD] |-> timer_reg >= hold_reg && finger_present_flag)
		else $error("hold flagged before delay elapsed");
	a_double_window: assert property (@(posedge clk) disable iff (!resetn)
		s_second_touch_late |=> state_reg == FPSC_IDLE)
		else $error("second tap accepted after window");
	a_motion_limit: assert property (@(posedge clk) disable iff (!resetn)
		flag_set != 3'b000 |-> sum_reg < {2'b00, limit_reg})
		else $error("gesture flagged above motion limit");
	a_flags_shown: assert property (@(posedge clk) disable iff (!resetn)
		flag_set[`FPSC_FLAG_DOUBLE] |-> ##2 gesture_flags[`FPSC_FLAG_DOUBLE])
		else $error("double tap not shown in flags");

	// release steps of the first and the second press
	sequence s_press_release;
		state_reg == FPSC_PRESS1 && !finger_present_flag;
	endsequence

	sequence s_second_release;
		state_reg == FPSC_PRESS2 && !finger_present_flag;
	endsequence

	// the first press starts its timer and sum from zero, the wait only its timer, the second press only its sum
	a_idle_restart: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == FPSC_IDLE |=> timer_reg == 8'h00 && sum_reg == 10'h000)
		else $error("timer or sum not cleared in idle");
	a_hold_jolt: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == FPSC_PRESS1 && hold_jolt |=> timer_reg == 8'h00)
		else $error("hold wait not restarted by jitter");
	a_hold_report: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == FPSC_PRESS1 && finger_present_flag && hold_en && hold_due && motion_ok
		|-> flag_set[`FPSC_FLAG_HOLD])
		else $error("hold not flagged once delay elapsed");
	// the double window is timed from the first release
	a_release_timer: assert property (@(posedge clk) disable iff (!resetn)
		s_press_release |=> timer_reg == 8'h00)
		else $error("window timer not started at release");
	a_release_limit: assert property (@(posedge clk) disable iff (!resetn)
		s_press_release ##0 !motion_ok |-> flag_set == 3'b000)
		else $error("moving tap produced a gesture");
	a_single_release: assert property (@(posedge clk) disable iff (!resetn)
		s_press_release ##0 (motion_ok && !double_en && single_en) |-> flag_set[`FPSC_FLAG_SINGLE])
		else $error("still tap not flagged as single");
	a_wait_timeout: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == FPSC_WAIT2 && window_out |-> flag_set[`FPSC_FLAG_SINGLE] == single_en)
		else $error("single tap wrong after window ran out");
	a_double_report: assert property (@(posedge clk) disable iff (!resetn)
		s_second_release ##0 motion_ok |-> flag_set[`FPSC_FLAG_DOUBLE])
		else $error("still second tap not flagged as double");
	a_double_source: assert property (@(posedge clk) disable iff (!resetn)
		flag_set[`FPSC_FLAG_DOUBLE] |-> state_reg == FPSC_PRESS2)
		else $error("double tap flagged outside second press");
	// one gesture per decision, so the host never sees two bits from one tap
	a_one_gesture: assert property (@(posedge clk) disable iff (!resetn)
		$onehot0(flag_set))
		else $error("more than one gesture flagged at once");
	a_held_quiet: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == FPSC_HELD |-> flag_set == 3'b000)
		else $error("gesture flagged while held");
	a_flags_mirror: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> gesture_flags == $past(flags_reg))
		else $error("gesture flags do not follow register");
endmodule

// ===== hdl/fpsc_cfg.svh
// Purpose: constants for finger presence status and soft tap detection
// Assumes: 200 MHz clk, register port driven by the serial engine
// Notes: tick is the unit of all time registers
`ifndef FPSC_CFG_SVH
`define FPSC_CFG_SVH

`define FPSC_ADDR_STATUS    8'h7a
`define FPSC_ADDR_CTRL      8'h7b
`define FPSC_ADDR_HOLD      8'h7c
`define FPSC_ADDR_WINDOW    8'h7d
`define FPSC_ADDR_LIMIT     8'h7e
`define FPSC_ADDR_FLAGS     8'h7f

`define FPSC_RST_STATUS     8'h00
`define FPSC_RST_CTRL       8'h25
`define FPSC_RST_HOLD       8'h45
`define FPSC_RST_WINDOW     8'h1e
`define FPSC_RST_LIMIT      8'h19
`define FPSC_RST_FLAGS      8'h00

`define FPSC_CTRL_SINGLE    0
`define FPSC_CTRL_DOUBLE    1
`define FPSC_CTRL_HOLD      2
`define FPSC_CTRL_LVL_LO    4
`define FPSC_CTRL_LVL_HI    6
`define FPSC_CTRL_MASK      8'h77
`define FPSC_FLAG_SINGLE    0
`define FPSC_FLAG_DOUBLE    1
`define FPSC_FLAG_HOLD      2

`define FPSC_FINGER_SCALE   3
`define FPSC_QUALITY_SCALE  2

`define FPSC_CLK_MHZ        200
`define FPSC_TICK_US        1000
`define FPSC_TICK_CYCLES    (`FPSC_TICK_US * `FPSC_CLK_MHZ)

`endif

// ===== hdl/fpsc_pkg.sv
// Purpose: types for soft tap detection
// Assumes: nothing
// Notes: state codes are binary
package fpsc_pkg;
	typedef enum logic [2:0] {
		FPSC_IDLE   = 3'b000,
		FPSC_PRESS1 = 3'b001,
		FPSC_WAIT2  = 3'b010,
		FPSC_PRESS2 = 3'b011,
		FPSC_HELD   = 3'b100
	} fpsc_state_t;
endpackage

// ===== hdl/fpsc_tick.sv
// Purpose: one-cycle tick enable from clk
// Assumes: TICK_CYCLES at least 2
// Notes: free running, restarts at reset
`timescale 1ns/10ps
module fpsc_tick #(
	parameter int TICK_CYCLES = 200000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// tick enable
	output logic      tick
);
	logic [31:0] cnt_reg;
	wire         wrap = (cnt_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_reg <= 32'h0000_0000;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
			tick    <= wrap;
		end
	end
endmodule

// ===== hdl/fpsc_regs.sv
// Purpose: register file for presence status and soft tap settings
// Assumes: one access per cycle from the serial engine
// Notes: read data registered, unmapped reads return zero
`timescale 1ns/10ps
`include "fpsc_cfg.svh"
module fpsc_regs import fpsc_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// status in, gesture events in
	input  wire logic [7:0] status_value,
	input  wire logic [2:0] flag_set,
	// settings and sticky gesture flags out
	output logic      [7:0] ctrl_reg,
	output logic      [7:0] hold_reg,
	output logic      [7:0] window_reg,
	output logic      [7:0] limit_reg,
	output logic      [2:0] flags_reg
);
	wire       hit_ctrl   = reg_wr && (reg_addr == `FPSC_ADDR_CTRL);
	wire       hit_hold   = reg_wr && (reg_addr == `FPSC_ADDR_HOLD);
	wire       hit_window = reg_wr && (reg_addr == `FPSC_ADDR_WINDOW);
	wire       hit_limit  = reg_wr && (reg_addr == `FPSC_ADDR_LIMIT);
	wire       hit_flags  = reg_wr && (reg_addr == `FPSC_ADDR_FLAGS);
	// host may only clear; a new event in the same cycle wins
	wire [2:0] flags_next = (hit_flags ? (flags_reg & reg_wdata[2:0]) : flags_reg) | flag_set;
	logic [7:0] rd_mux;

	always_comb begin
		if (reg_addr == `FPSC_ADDR_STATUS)
			rd_mux = status_value;
		else if (reg_addr == `FPSC_ADDR_CTRL)
			rd_mux = ctrl_reg;
		else if (reg_addr == `FPSC_ADDR_HOLD)
			rd_mux = hold_reg;
		else if (reg_addr == `FPSC_ADDR_WINDOW)
			rd_mux = window_reg;
		else if (reg_addr == `FPSC_ADDR_LIMIT)
			rd_mux = limit_reg;
		else if (reg_addr == `FPSC_ADDR_FLAGS)
			rd_mux = {5'b0_0000, flags_reg};
		else
			rd_mux = 8'h00;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_reg   <= `FPSC_RST_CTRL;
			hold_reg   <= `FPSC_RST_HOLD;
			window_reg <= `FPSC_RST_WINDOW;
			limit_reg  <= `FPSC_RST_LIMIT;
			flags_reg  <= 3'b000;
			reg_rdata  <= 8'h00;
		end else begin
			if (hit_ctrl)
				ctrl_reg <= reg_wdata & `FPSC_CTRL_MASK;
			if (hit_hold)
				hold_reg <= reg_wdata;
			if (hit_window)
				window_reg <= reg_wdata;
			if (hit_limit)
				limit_reg <= reg_wdata;
			flags_reg <= flags_next;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

	a_status_read: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == `FPSC_ADDR_STATUS |=> reg_rdata == $past(status_value))
		else $error("status read data wrong");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
		flags_reg[0] && !hit_flags |=> flags_reg[0])
		else $error("flag dropped without host write");
	a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
		hit_flags && !reg_wdata[1] && !flag_set[1] |=> !flags_reg[1])
		else $error("flag not cleared by host write");
endmodule

// ===== tb/fpsc_host.sv
// Purpose: host and finger source model facing the soft tap block
// Assumes: tasks are called from one process at a time
// Notes: deltas scramble outside a sample so stale values never look valid
`timescale 1ns/10ps
module fpsc_host (
	// clock
	input  wire logic clk,
	// register port
	output logic [7:0] reg_addr,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_wdata,
	// finger and motion
	output logic       finger_present_flag,
	output logic [3:0] finger_hyst_bound,
	output logic [2:0] quality_hyst_bound,
	output logic       motion_valid,
	output logic [7:0] delta_x,
	output logic [7:0] delta_y
);
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
		{finger_present_flag, finger_hyst_bound, quality_hyst_bound} = '0;
		{motion_valid, delta_x, delta_y} = '0;
	end
	// one register cycle; read data is settled when this returns
	task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wr <= w;
		reg_rd <= !w;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask
	// finger detect outputs: bound nibble, quality field, present bit
	task automatic finger(input logic [7:0] r);
		finger_hyst_bound <= r[7:4];
		quality_hyst_bound <= r[3:1];
		finger_present_flag <= r[0];
	endtask
	// press, one motion sample at 500 cpi, hold, release
	task automatic tap(input int dx, input int dy, input int cycles);
		@(posedge clk);
		finger_present_flag <= 1'b1;
		@(posedge clk);
		motion_valid <= 1'b1;
		delta_x <= dx[7:0];
		delta_y <= dy[7:0];
		@(posedge clk);
		motion_valid <= 1'b0;
		delta_x <= ~delta_x;
		delta_y <= ~delta_y;
		repeat (cycles) @(posedge clk);
		finger_present_flag <= 1'b0;
	endtask
endmodule

// ===== tb/fpsc_tb_top.sv
// Purpose: self-checking bench for presence status and soft tap gestures
// Assumes: tick shortened to 4 clk so time registers stay small
// Notes: limit stays at its reset value 25 for every tap case
`timescale 1ns/10ps
module tb_top;
	localparam int TK = 4;
	logic       clk;
	logic       resetn;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, delta_x, delta_y, r;
	logic       reg_wr, reg_rd, finger_present_flag, motion_valid;
	logic [3:0] finger_hyst_bound;
	logic [2:0] quality_hyst_bound, gesture_flags;
	logic [6:0] finger_hyst_threshold;
	logic [4:0] quality_hyst_threshold;
	int         fail_count = 0;
	int         comparisons = 0;
	int         seed = 32'h5fd3_f780;
	int         k;
	// tap cases: control, hold delay, first sample, second tap (99 = none)
	logic [7:0] cs [10] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h03, 8'h03, 8'h02, 8'h74, 8'h71, 8'h75};
	logic [7:0] hs [10] = '{8'h45, 8'h45, 8'h45, 8'h45, 8'h45, 8'h45, 8'h45, 8'h02, 8'h02, 8'h14};
	int         ax [10] = '{-3, 12, 13, -3, 1, 1, 1, 1, 1, 1};
	int         ay [10] = '{2, -12, -12, 2, 1, 1, 1, 1, 1, 1};
	int         cy [10] = '{8, 8, 8, 8, 8, 8, 8, 40, 40, 40};
	int         bx [10] = '{99, 99, 99, 99, 0, 99, 0, 99, 99, 99};
	fpsc_top #(.TICK_CYCLES(TK)) uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .finger_present_flag(finger_present_flag),
		.finger_hyst_bound(finger_hyst_bound), .quality_hyst_bound(quality_hyst_bound),
		.motion_valid(motion_valid), .delta_x(delta_x), .delta_y(delta_y),
		.finger_hyst_threshold(finger_hyst_threshold), .quality_hyst_threshold(quality_hyst_threshold),
		.gesture_flags(gesture_flags));
	fpsc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.finger_present_flag(finger_present_flag), .finger_hyst_bound(finger_hyst_bound),
		.quality_hyst_bound(quality_hyst_bound), .motion_valid(motion_valid), .delta_x(delta_x), .delta_y(delta_y));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		host.access(a, 1'b0, 8'h00);
		check(what, reg_rdata, exp);
	endtask
	function automatic int mag(input int v);
		return (v < 0) ? -v : v;
	endfunction
	// reference model of one press plus an optional second press
	function automatic logic [2:0] predict(input logic [7:0] c, input int hold, input int s1, input int ticks,
		input int s2);
		if (s1 >= 25) return 3'h0;
		if (c[2] && ticks >= hold) return 3'h4;
		if (c[1]) return (s2 < 0) ? {2'h0, c[0]} : {1'b0, s2 < 25, 1'b0};
		return {2'h0, c[0]};
	endfunction
	// waits long after the flag so a sticky bit must still be there
	task automatic expect_gesture(input logic [2:0] exp);
		for (k = 0; k < 200 && gesture_flags === 3'h0 && exp !== 3'h0; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 200) begin
			fail_count++;
			give_verdict();
		end
		repeat (60) @(posedge clk);
		#1;
		check("gesture_flags", {5'h00, gesture_flags}, {5'h00, exp});
		rd(8'h7f, {5'h00, exp}, "soft_tap_flags");
		host.access(8'h7f, 1'b1, 8'h00);
		rd(8'h7f, 8'h00, "soft_tap_flags cleared");
	endtask
	initial begin
		#400000;
		fail_count++;
		give_verdict();
	end
	initial begin
		resetn = 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h7a, 8'h00, "finger_detect_status");
		rd(8'h7b, 8'h25, "soft_tap_control");
		rd(8'h7c, 8'h45, "press_hold_delay");
		rd(8'h7d, 8'h1e, "double_tap_window");
		rd(8'h7e, 8'h19, "tap_motion_limit");
		rd(8'h7f, 8'h00, "soft_tap_flags");
		rd(8'h10, 8'h00, "unmapped");
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			@(posedge clk);
			host.finger(r);
			host.access(8'h7a, 1'b1, ~r);
			rd(8'h7a, r, "finger_detect_status");
			check("finger threshold", {1'b0, finger_hyst_threshold}, {1'b0, r[7:4], 3'h0});
			check("quality threshold", {3'h0, quality_hyst_threshold}, {3'h0, r[3:1], 2'h0});
		end
		@(posedge clk);
		host.finger(8'h00);
		repeat (10) @(posedge clk);
		host.access(8'h7f, 1'b1, 8'h00);
		$display("test status done");
		host.access(8'h7b, 1'b1, 8'hff);
		rd(8'h7b, 8'h77, "soft_tap_control reserved");
		host.access(8'h7d, 1'b1, 8'h03);
		rd(8'h7d, 8'h03, "double_tap_window");
		for (int i = 0; i < 10; i++) begin
			host.access(8'h7b, 1'b1, cs[i]);
			host.access(8'h7c, 1'b1, hs[i]);
			host.tap(ax[i], ay[i], cy[i]);
			if (bx[i] != 99) begin
				repeat (3) @(posedge clk);
				host.tap(bx[i], 2, 6);
			end
			expect_gesture(predict(cs[i], hs[i], mag(ax[i]) + mag(ay[i]), (cy[i] + 2) / TK,
				(bx[i] == 99) ? -1 : bx[i] + 2));
			$display("test tap case %0d done", i);
		end
		give_verdict();
	end
endmodule
